//--- inc/rdsel_pkg.sv
// package: register map, setting codes, boost tables and level decode
package rdsel_pkg;
   // ********************************
   // register map
   // ********************************
   localparam logic [7:0] RDSEL_DRIVE_CFG_OFS = 8'h00; // drive_config_byte
   localparam logic [7:0] RDSEL_BOOST_MODE_OFS = 8'h01; // boost_mode_byte
   localparam logic [7:0] RDSEL_DRIVE_CFG_RST = 8'h06; // 1200mV swing, 6dB pre-emphasis
   localparam logic [7:0] RDSEL_BOOST_MODE_RST = 8'h00;
   localparam logic [7:0] RDSEL_BOOST_MODE_MASK = 8'h0F; // upper nibble reserved, reads zero
   localparam logic [7:0] RDSEL_RDATA_RST = 8'h00; // also the answer to unmapped reads
   // ********************************
   // field positions
   // ********************************
   localparam int RDSEL_BAND_POS = 4; // boost band bit in drive_config_byte
   localparam int RDSEL_LOW_POS = 5; // boost code low bits, three wide
   localparam int RDSEL_PE_POS = 2; // pre-emphasis setting, two wide
   localparam int RDSEL_SW_POS = 0; // swing setting, two wide
   localparam int RDSEL_ABS_POS = 0; // adaptive boost select in boost_mode_byte
   localparam int RDSEL_LVL_POS = 2; // boost level in boost_mode_byte
   // ********************************
   // three-level and setting codes
   // ********************************
   localparam logic [1:0] RDSEL_TL_LOW = 2'h0;
   localparam logic [1:0] RDSEL_TL_MID = 2'h1;
   localparam logic [1:0] RDSEL_TL_HIGH = 2'h3;
   localparam logic [1:0] RDSEL_SWING_800MV = 2'h3;
   localparam logic [1:0] RDSEL_SWING_RST = 2'h2; // 1200mV
   localparam logic [1:0] RDSEL_PE_0DB = 2'h3;
   localparam logic [1:0] RDSEL_PE_RST = 2'h1; // 6dB
   localparam logic [3:0] RDSEL_BOOST_RST = 4'h0;
   // ********************************
   // boost tables, entry n at bits 4n+3:4n, n = pre-emphasis
   // ********************************
   localparam logic [15:0] RDSEL_ADAPT_LOW_TBL = 16'h037A;
   localparam logic [15:0] RDSEL_ADAPT_MID_TBL = 16'h37AD;
   localparam logic [15:0] RDSEL_ADAPT_HIGH_TBL = 16'h9BDF;
   localparam logic [3:0] RDSEL_FIXED_LOW = 4'h0;
   localparam logic [3:0] RDSEL_FIXED_MID = 4'hC;
   localparam logic [3:0] RDSEL_FIXED_HIGH = 4'hF;

   // decoded three-level input
   typedef enum logic [2:0] {RDSEL_LOW = 3'h1, RDSEL_MID = 3'h2, RDSEL_HIGH = 3'h4} rdsel_level_e;

   // reserved code 10 decodes as middle so no input is left undefined
   function automatic rdsel_level_e rdsel_decode_level(input logic [1:0] code);
      case (code)
         RDSEL_TL_LOW: return RDSEL_LOW;
         RDSEL_TL_HIGH: return RDSEL_HIGH;
         default: return RDSEL_MID;
      endcase
   endfunction

   // picks one nibble of a boost table by pre-emphasis setting
   function automatic logic [3:0] rdsel_table_pick(input logic [15:0] tbl, input logic [1:0] pe);
      return tbl[{pe, 2'h0} +: 4];
   endfunction
endpackage

//--- inc/rdsel_sel_if.sv
// interface: selected sources passed between the select submodules
`timescale 1ns/1ps
interface rdsel_sel_if;
   rdsel_pkg::rdsel_level_e ctl_level; // decoded control source
   rdsel_pkg::rdsel_level_e abs_level; // effective adaptive boost select
   rdsel_pkg::rdsel_level_e lvl_level; // effective boost level
   logic [1:0] swing_setting; // chosen swing
   logic [1:0] preemphasis_setting; // chosen pre-emphasis
   logic [3:0] pin_code; // boost code built from swing and pre-emphasis pins
   logic [3:0] reg_code; // boost code held in drive_config_byte
   logic [3:0] boost_code; // final boost code
   modport mux (output ctl_level, abs_level, lvl_level, swing_setting, preemphasis_setting, pin_code, reg_code);
   modport map (input ctl_level, abs_level, lvl_level, preemphasis_setting, pin_code, reg_code,
                output boost_code);
   modport top (input boost_code, swing_setting, preemphasis_setting);
endinterface

//--- design/rdsel_source_mux.sv
// module: picks register, pin or listener sources by control source level
`timescale 1ns/1ps
module rdsel_source_mux (
   input wire logic [7:0] drive_config_byte_in,
   input wire logic [7:0] boost_mode_byte_in,
   input wire logic [1:0] control_source_pin_in,
   input wire logic [1:0] adaptive_boost_select_in,
   input wire logic [1:0] boost_level_pin_in,
   input wire logic swing_pin_zero_in,
   input wire logic swing_pin_one_in,
   input wire logic preemphasis_pin_zero_in,
   input wire logic preemphasis_pin_one_in,
   input wire logic cable_adapter_detect_in,
   input wire logic [1:0] aux_swing_in,
   input wire logic [1:0] aux_preemphasis_in,
   rdsel_sel_if.mux sel
);
   import rdsel_pkg::*;
   rdsel_level_e ctl; // local copy, avoids reading back the interface

   // ********************************
   // source selection
   // ********************************
   always_comb begin
      ctl = rdsel_decode_level(control_source_pin_in);
      sel.ctl_level = ctl;
      sel.pin_code = {swing_pin_zero_in, preemphasis_pin_one_in, preemphasis_pin_zero_in, swing_pin_one_in};
      sel.reg_code = {drive_config_byte_in[RDSEL_BAND_POS], drive_config_byte_in[RDSEL_LOW_POS +: 3]};
      case (ctl)
         RDSEL_LOW: begin
            // register mode: both bytes govern
            sel.abs_level = rdsel_decode_level(boost_mode_byte_in[RDSEL_ABS_POS +: 2]);
            sel.lvl_level = rdsel_decode_level(boost_mode_byte_in[RDSEL_LVL_POS +: 2]);
            sel.swing_setting = drive_config_byte_in[RDSEL_SW_POS +: 2];
            sel.preemphasis_setting = drive_config_byte_in[RDSEL_PE_POS +: 2];
         end
         RDSEL_HIGH: begin
            // pin mode
            sel.abs_level = rdsel_decode_level(adaptive_boost_select_in);
            sel.lvl_level = rdsel_decode_level(boost_level_pin_in);
            sel.swing_setting = {swing_pin_one_in, swing_pin_zero_in};
            sel.preemphasis_setting = {preemphasis_pin_one_in, preemphasis_pin_zero_in};
         end
         default: begin
            // middle: listener drives unless a cable adapter is seen
            sel.abs_level = rdsel_decode_level(adaptive_boost_select_in);
            sel.lvl_level = rdsel_decode_level(boost_level_pin_in);
            sel.swing_setting = cable_adapter_detect_in ? RDSEL_SWING_800MV : aux_swing_in;
            sel.preemphasis_setting = cable_adapter_detect_in ? RDSEL_PE_0DB : aux_preemphasis_in;
         end
      endcase
   end
endmodule // rdsel_source_mux

//--- design/rdsel_boost_map.sv
// module: maps selected mode, level and pre-emphasis to a boost code
`timescale 1ns/1ps
module rdsel_boost_map (
   rdsel_sel_if.map sel
);
   import rdsel_pkg::*;

   // ********************************
   // boost code decision
   // ********************************
   always_comb begin
      case (sel.abs_level)
         RDSEL_LOW: begin
            if (sel.ctl_level == RDSEL_LOW) begin
               // register mode with adaptive off: code taken as written
               sel.boost_code = sel.reg_code;
            end else begin
               // fixed pin mode, same at every link rate
               case (sel.lvl_level)
                  RDSEL_LOW: sel.boost_code = RDSEL_FIXED_LOW;
                  RDSEL_HIGH: sel.boost_code = RDSEL_FIXED_HIGH;
                  default: sel.boost_code = RDSEL_FIXED_MID;
               endcase
            end
         end
         RDSEL_MID: begin
            if (sel.ctl_level == RDSEL_MID) begin
               sel.boost_code = sel.pin_code;
            end else begin
               // lone middle select falls back to adaptive
               sel.boost_code = rdsel_table_pick(RDSEL_ADAPT_MID_TBL, sel.preemphasis_setting);
            end
         end
         default: begin
            // adaptive: table row follows the boost level
            case (sel.lvl_level)
               RDSEL_LOW: sel.boost_code = rdsel_table_pick(RDSEL_ADAPT_LOW_TBL, sel.preemphasis_setting);
               RDSEL_HIGH: sel.boost_code = rdsel_table_pick(RDSEL_ADAPT_HIGH_TBL, sel.preemphasis_setting);
               default: sel.boost_code = rdsel_table_pick(RDSEL_ADAPT_MID_TBL, sel.preemphasis_setting);
            endcase
         end
      endcase
   end
endmodule // rdsel_boost_map

//--- design/rdsel_top.sv
// module: drive setting select top, config bytes, output registers, checks
`timescale 1ns/1ps
module rdsel_top (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic cfg_wr_in,
   input wire logic cfg_rd_in,
   input wire logic [7:0] cfg_addr_in,
   input wire logic [7:0] cfg_wdata_in,
   input wire logic [1:0] control_source_pin_in,
   input wire logic [1:0] adaptive_boost_select_in,
   input wire logic [1:0] boost_level_pin_in,
   input wire logic swing_pin_zero_in,
   input wire logic swing_pin_one_in,
   input wire logic preemphasis_pin_zero_in,
   input wire logic preemphasis_pin_one_in,
   input wire logic cable_adapter_detect_in,
   input wire logic [1:0] aux_swing_in,
   input wire logic [1:0] aux_preemphasis_in,
   output logic [7:0] cfg_rdata_out,
   output logic [3:0] boost_code_out,
   output logic [1:0] swing_setting_out,
   output logic [1:0] preemphasis_setting_out
);
   import rdsel_pkg::*;

   // ********************************
   // declarations
   // ********************************
   logic [7:0] drive_config_byte; // boost, pre-emphasis and swing fields
   logic [7:0] boost_mode_byte; // stand-in for select and level pins
   logic [7:0] next_drive_config_byte;
   logic [7:0] next_boost_mode_byte;
   logic [7:0] next_cfg_rdata; // read answer for the next cycle
   logic [3:0] next_boost_code;
   logic [1:0] next_swing_setting;
   logic [1:0] next_preemphasis_setting;

   rdsel_sel_if sel (); // carries the selected sources

   // ********************************
   // source selection and boost map
   // ********************************
   rdsel_source_mux u_mux (
      .drive_config_byte_in(drive_config_byte),
      .boost_mode_byte_in(boost_mode_byte),
      .control_source_pin_in(control_source_pin_in),
      .adaptive_boost_select_in(adaptive_boost_select_in),
      .boost_level_pin_in(boost_level_pin_in),
      .swing_pin_zero_in(swing_pin_zero_in),
      .swing_pin_one_in(swing_pin_one_in),
      .preemphasis_pin_zero_in(preemphasis_pin_zero_in),
      .preemphasis_pin_one_in(preemphasis_pin_one_in),
      .cable_adapter_detect_in(cable_adapter_detect_in),
      .aux_swing_in(aux_swing_in),
      .aux_preemphasis_in(aux_preemphasis_in),
      .sel(sel.mux)
   );

   rdsel_boost_map u_map (
      .sel(sel.map)
   );

   // ********************************
   // configuration bytes
   // ********************************
   // writes land next edge; reserved bits of boost_mode_byte are never stored
   always_comb begin
      next_drive_config_byte = drive_config_byte;
      next_boost_mode_byte = boost_mode_byte;
      if (cfg_wr_in) begin
         if (cfg_addr_in == RDSEL_DRIVE_CFG_OFS) begin
            next_drive_config_byte = cfg_wdata_in;
         end else if (cfg_addr_in == RDSEL_BOOST_MODE_OFS) begin
            next_boost_mode_byte = cfg_wdata_in & RDSEL_BOOST_MODE_MASK;
         end
      end
   end

   // read answer: a read in the same cycle as a write returns the old value
   always_comb begin
      next_cfg_rdata = cfg_rdata_out;
      if (cfg_rd_in) begin
         case (cfg_addr_in)
            RDSEL_DRIVE_CFG_OFS: next_cfg_rdata = drive_config_byte;
            RDSEL_BOOST_MODE_OFS: next_cfg_rdata = boost_mode_byte;
            default: next_cfg_rdata = RDSEL_RDATA_RST; // unmapped reads zero
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         drive_config_byte <= RDSEL_DRIVE_CFG_RST;
         boost_mode_byte <= RDSEL_BOOST_MODE_RST;
         cfg_rdata_out <= RDSEL_RDATA_RST;
      end else begin
         drive_config_byte <= next_drive_config_byte;
         boost_mode_byte <= next_boost_mode_byte;
         cfg_rdata_out <= next_cfg_rdata;
      end
   end

   // ********************************
   // output settings
   // ********************************
   // registered so the analog side never sees a decode glitch; costs one cycle
   always_comb begin
      next_boost_code = sel.boost_code;
      next_swing_setting = sel.swing_setting;
      next_preemphasis_setting = sel.preemphasis_setting;
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         boost_code_out <= RDSEL_BOOST_RST;
         swing_setting_out <= RDSEL_SWING_RST;
         preemphasis_setting_out <= RDSEL_PE_RST;
      end else begin
         boost_code_out <= next_boost_code;
         swing_setting_out <= next_swing_setting;
         preemphasis_setting_out <= next_preemphasis_setting;
      end
   end

   // ********************************
   // checks
   // ********************************
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!reset_n_in);

   // shorthand for the pin-mode conditions used below
   logic ctl_low;
   logic ctl_mid;
   logic ctl_high;
   logic abs_pin_high;
   logic [1:0] pe_pins; // pre-emphasis pins as one field
   assign ctl_low = (control_source_pin_in == RDSEL_TL_LOW);
   assign ctl_mid = (control_source_pin_in == RDSEL_TL_MID);
   assign ctl_high = (control_source_pin_in == RDSEL_TL_HIGH);
   assign abs_pin_high = (adaptive_boost_select_in == RDSEL_TL_HIGH);
   assign pe_pins = {preemphasis_pin_one_in, preemphasis_pin_zero_in};

   // register mode with adaptive off passes the written code through
   chk_reg_code_pass: assert property (
      ctl_low && boost_mode_byte[RDSEL_ABS_POS +: 2] == RDSEL_TL_LOW
      |=> boost_code_out == {$past(drive_config_byte[RDSEL_BAND_POS]), $past(drive_config_byte[7:5])})
      else $error("register boost code not passed through");

   chk_adapt_low_row: assert property (
      ctl_high && abs_pin_high && boost_level_pin_in == RDSEL_TL_LOW
      && {preemphasis_pin_one_in, preemphasis_pin_zero_in} == 2'h0
      |=> boost_code_out == 4'hA)
      else $error("adaptive low row wrong");

   chk_adapt_mid_row: assert property (
      ctl_high && abs_pin_high && boost_level_pin_in == RDSEL_TL_MID
      && {preemphasis_pin_one_in, preemphasis_pin_zero_in} == 2'h2
      |=> boost_code_out == 4'h7)
      else $error("adaptive middle row wrong");

   chk_adapt_high_row: assert property (
      ctl_high && abs_pin_high && boost_level_pin_in == RDSEL_TL_HIGH
      && {preemphasis_pin_one_in, preemphasis_pin_zero_in} == 2'h3
      |=> boost_code_out == 4'h9)
      else $error("adaptive high row wrong");

   chk_fixed_pin_mode: assert property (
      ctl_high && adaptive_boost_select_in == RDSEL_TL_LOW && boost_level_pin_in == RDSEL_TL_MID
      |=> boost_code_out == 4'hC)
      else $error("fixed middle boost wrong");

   chk_pin_built_code: assert property (
      ctl_mid && adaptive_boost_select_in == RDSEL_TL_MID
      |=> boost_code_out == {$past(swing_pin_zero_in), $past(preemphasis_pin_one_in),
                             $past(preemphasis_pin_zero_in), $past(swing_pin_one_in)})
      else $error("pin built boost code wrong");

   // a written swing reaches the output two edges after the write
   chk_swing_reg_path: assert property (
      cfg_wr_in && cfg_addr_in == RDSEL_DRIVE_CFG_OFS && ctl_low ##1 ctl_low && !cfg_wr_in
      |=> swing_setting_out == $past(cfg_wdata_in[RDSEL_SW_POS +: 2], 2))
      else $error("register swing not applied");

   chk_swing_pin_path: assert property (
      ctl_high |=> swing_setting_out == $past({swing_pin_one_in, swing_pin_zero_in}))
      else $error("pin swing not applied");

   chk_swing_listener: assert property (
      ctl_mid |=> swing_setting_out == ($past(cable_adapter_detect_in) ? RDSEL_SWING_800MV : $past(aux_swing_in)))
      else $error("listener swing or adapter override wrong");

   chk_pe_sources: assert property (
      ctl_low |=> preemphasis_setting_out == $past(drive_config_byte[RDSEL_PE_POS +: 2]))
      else $error("register pre-emphasis not applied");

   chk_pe_listener: assert property (
      ctl_mid && cable_adapter_detect_in |=> preemphasis_setting_out == RDSEL_PE_0DB)
      else $error("adapter did not force 0dB");

   // byte 1 set to adaptive high, level middle drives the middle row
   chk_mode_byte_sub: assert property (
      ctl_low && boost_mode_byte == 8'h07 && drive_config_byte[RDSEL_PE_POS +: 2] == 2'h1
      |=> boost_code_out == 4'hA)
      else $error("boost_mode_byte did not stand in for pins");

   chk_reserved_mid: assert property (
      ctl_high && adaptive_boost_select_in == RDSEL_TL_LOW && boost_level_pin_in == 2'h2
      |=> boost_code_out == 4'hC)
      else $error("reserved level code not taken as middle");

   chk_reserved_read: assert property (
      cfg_rd_in && cfg_addr_in == RDSEL_BOOST_MODE_OFS |=> cfg_rdata_out[7:4] == 4'h0)
      else $error("reserved bits read nonzero");

   // ********************************
   // remaining table entries and write paths
   // ********************************
   // one entry per property so a failure points at a single table cell
   chk_adapt_low_pe1: assert property (
      ctl_high && abs_pin_high && boost_level_pin_in == RDSEL_TL_LOW && pe_pins == 2'h1
      |=> boost_code_out == 4'h7)
      else $error("adaptive low row entry 1 wrong");

   chk_adapt_low_pe2: assert property (
      ctl_high && abs_pin_high && boost_level_pin_in == RDSEL_TL_LOW && pe_pins == 2'h2
      |=> boost_code_out == 4'h3)
      else $error("adaptive low row entry 2 wrong");

   chk_adapt_low_pe3: assert property (
      ctl_high && abs_pin_high && boost_level_pin_in == RDSEL_TL_LOW && pe_pins == 2'h3
      |=> boost_code_out == 4'h0)
      else $error("adaptive low row entry 3 wrong");

   chk_adapt_mid_pe0: assert property (
      ctl_high && abs_pin_high && boost_level_pin_in == RDSEL_TL_MID && pe_pins == 2'h0
      |=> boost_code_out == 4'hD)
      else $error("adaptive middle row entry 0 wrong");

   chk_adapt_mid_pe1: assert property (
      ctl_high && abs_pin_high && boost_level_pin_in == RDSEL_TL_MID && pe_pins == 2'h1
      |=> boost_code_out == 4'hA)
      else $error("adaptive middle row entry 1 wrong");

   chk_adapt_mid_pe3: assert property (
      ctl_high && abs_pin_high && boost_level_pin_in == RDSEL_TL_MID && pe_pins == 2'h3
      |=> boost_code_out == 4'h3)
      else $error("adaptive middle row entry 3 wrong");

   chk_adapt_high_pe0: assert property (
      ctl_high && abs_pin_high && boost_level_pin_in == RDSEL_TL_HIGH && pe_pins == 2'h0
      |=> boost_code_out == 4'hF)
      else $error("adaptive high row entry 0 wrong");

   chk_adapt_high_pe1: assert property (
      ctl_high && abs_pin_high && boost_level_pin_in == RDSEL_TL_HIGH && pe_pins == 2'h1
      |=> boost_code_out == 4'hD)
      else $error("adaptive high row entry 1 wrong");

   chk_adapt_high_pe2: assert property (
      ctl_high && abs_pin_high && boost_level_pin_in == RDSEL_TL_HIGH && pe_pins == 2'h2
      |=> boost_code_out == 4'hB)
      else $error("adaptive high row entry 2 wrong");

   chk_fixed_low_level: assert property (
      ctl_high && adaptive_boost_select_in == RDSEL_TL_LOW && boost_level_pin_in == RDSEL_TL_LOW
      |=> boost_code_out == 4'h0)
      else $error("fixed low boost wrong");

   chk_fixed_high_level: assert property (
      ctl_high && adaptive_boost_select_in == RDSEL_TL_LOW && boost_level_pin_in == RDSEL_TL_HIGH
      |=> boost_code_out == 4'hF)
      else $error("fixed high boost wrong");

   chk_pe_pin_path: assert property (
      ctl_high |=> preemphasis_setting_out == $past(pe_pins))
      else $error("pin pre-emphasis not applied");

   chk_pe_follow_aux: assert property (
      ctl_mid && !cable_adapter_detect_in |=> preemphasis_setting_out == $past(aux_preemphasis_in))
      else $error("listener pre-emphasis not followed");

   chk_drive_cfg_write: assert property (
      cfg_wr_in && cfg_addr_in == RDSEL_DRIVE_CFG_OFS |=> drive_config_byte == $past(cfg_wdata_in))
      else $error("drive_config_byte write lost");

   chk_mode_byte_write: assert property (
      cfg_wr_in && cfg_addr_in == RDSEL_BOOST_MODE_OFS |=> boost_mode_byte == ($past(cfg_wdata_in) & 8'h0F))
      else $error("boost_mode_byte write lost");

   // main scenarios
   cov_register_mode: cover property (ctl_low ##1 cfg_wr_in ##2 ctl_low);
   cov_adapter_override: cover property (ctl_mid && cable_adapter_detect_in ##1 ctl_mid && !cable_adapter_detect_in);
   cov_adaptive_pins: cover property (ctl_high && abs_pin_high ##1 boost_code_out == 4'hF);
   cov_pin_built: cover property (ctl_mid && adaptive_boost_select_in == RDSEL_TL_MID);
   cov_reserved_level: cover property (ctl_high && boost_level_pin_in == 2'h2);

endmodule // rdsel_top

//--- dv/rdsel_pin_model.sv
// partner model: strap pins and aux listener outputs
`timescale 1ns/1ps
module rdsel_pin_model (
   input wire logic mclk_in,
   input wire logic load_in,
   input wire logic [15:0] word_in,
   output logic [1:0] ctl_out,
   output logic [1:0] abs_out,
   output logic [1:0] lvl_out,
   output logic sw0_out,
   output logic sw1_out,
   output logic pe0_out,
   output logic pe1_out,
   output logic cad_out,
   output logic [1:0] aux_sw_out,
   output logic [1:0] aux_pe_out
);
   // ******
   // strap levels
   // ******
   // a real strap cannot sit at code 10; only a commanded load uses it
   function automatic logic [1:0] lvl(input logic [1:0] c, input logic rsv);
      return (c == 2'h2 && !rsv) ? 2'h3 : c;
   endfunction
   // pins start low, all loads land on the rising edge
   initial begin
      {ctl_out, abs_out, lvl_out, sw0_out, sw1_out, pe0_out, pe1_out} = '0;
      {cad_out, aux_sw_out, aux_pe_out} = '0;
   end
   // straps held as levels between loads
   always @(posedge mclk_in) begin
      if (load_in) begin
         ctl_out <= lvl(word_in[1:0], word_in[15]);
         abs_out <= lvl(word_in[3:2], word_in[15]);
         lvl_out <= lvl(word_in[5:4], word_in[15]);
         {sw1_out, sw0_out, pe1_out, pe0_out} <= word_in[9:6];
         cad_out <= word_in[10];
         aux_sw_out <= word_in[12:11];
         aux_pe_out <= word_in[14:13];
      end
   end
endmodule // rdsel_pin_model

//--- dv/rdsel_bench.sv
// testbench: drive setting select against a behavioural model
`timescale 1ns/1ps
module rdsel_bench;
   import rdsel_pkg::*;
   // ******
   // signals
   // ******
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   logic [7:0] cfg_addr = 8'h00;
   logic [7:0] cfg_wdata = 8'h00;
   logic ld = 1'b0;
   logic [15:0] word = 16'h0000;
   logic [1:0] ctl_p, abs_p, lvl_p, aux_sw, aux_pe;
   logic sw0, sw1, pe0, pe1, cad;
   logic [7:0] cfg_rdata_out;
   logic [3:0] boost_code_out;
   logic [1:0] swing_setting_out, preemphasis_setting_out;
   logic [7:0] b0, b1; // bench copies of the two bytes
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;
   // 40 MHz clock
   always #12.5 mclk_in = ~mclk_in;
   // ******
   // instances
   // ******
   rdsel_pin_model PINS (.mclk_in(mclk_in), .load_in(ld), .word_in(word), .ctl_out(ctl_p),
      .abs_out(abs_p), .lvl_out(lvl_p), .sw0_out(sw0), .sw1_out(sw1), .pe0_out(pe0),
      .pe1_out(pe1), .cad_out(cad), .aux_sw_out(aux_sw), .aux_pe_out(aux_pe));
   rdsel_top DUT (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .cfg_wr_in(cfg_wr),
      .cfg_rd_in(cfg_rd), .cfg_addr_in(cfg_addr), .cfg_wdata_in(cfg_wdata),
      .control_source_pin_in(ctl_p), .adaptive_boost_select_in(abs_p),
      .boost_level_pin_in(lvl_p), .swing_pin_zero_in(sw0), .swing_pin_one_in(sw1),
      .preemphasis_pin_zero_in(pe0), .preemphasis_pin_one_in(pe1),
      .cable_adapter_detect_in(cad), .aux_swing_in(aux_sw), .aux_preemphasis_in(aux_pe),
      .cfg_rdata_out(cfg_rdata_out), .boost_code_out(boost_code_out),
      .swing_setting_out(swing_setting_out), .preemphasis_setting_out(preemphasis_setting_out));
   // ******
   // reporting
   // ******
   task automatic stop_test();
      if (miscompares == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", name, e, g);
         miscompares++;
      end
   endtask
   // hang guard, about three and a half times the expected run
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 10000) begin
         miscompares++;
         stop_test();
      end
   end
   // ******
   // model
   // ******
   // three-level decode; reserved 10 counts as middle
   function automatic int lv(input logic [1:0] c);
      return c == 2'h0 ? 0 : (c == 2'h3 ? 2 : 1);
   endfunction
   // expected {boost, swing, pre-emphasis} from bytes and pins
   function automatic logic [7:0] model();
      int atab[3][4] = '{'{10, 7, 3, 0}, '{13, 10, 7, 3}, '{15, 13, 11, 9}};
      int ftab[3] = '{0, 12, 15};
      int c, a, l, sw, pe, bst;
      c = lv(ctl_p);
      a = lv(c == 0 ? b1[1:0] : abs_p);
      l = lv(c == 0 ? b1[3:2] : lvl_p);
      sw = c == 0 ? b0[1:0] : (c == 2 ? {sw1, sw0} : (cad ? 3 : aux_sw));
      pe = c == 0 ? b0[3:2] : (c == 2 ? {pe1, pe0} : (cad ? 3 : aux_pe));
      if (a == 1 && c == 1)
         bst = {sw0, pe1, pe0, sw1};
      else if (a == 0)
         bst = c == 0 ? {b0[4], b0[7:5]} : ftab[l];
      else
         bst = atab[a == 1 ? 1 : l][pe]; // lone middle select always uses the middle row
      return {bst[3:0], sw[1:0], pe[1:0]};
   endfunction
   // ******
   // drivers
   // ******
   // one-cycle write strobe, taken at the second edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge mclk_in);
      cfg_wr <= 1'b0;
   endtask
   // read data stands just after the taking edge
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge mclk_in);
      cfg_rd <= 1'b0;
      #1 chk("cfg_rdata", e, cfg_rdata_out);
   endtask
   // pins move one edge after the load, outputs one edge later
   task automatic pins(input logic [15:0] w);
      @(posedge mclk_in);
      ld <= 1'b1;
      word <= w;
      @(posedge mclk_in);
      ld <= 1'b0;
      @(posedge mclk_in);
      #1;
   endtask
   task automatic check();
      logic [7:0] e;
      e = model();
      chk("boost", {4'h0, e[7:4]}, {4'h0, boost_code_out});
      chk("swing", {6'h00, e[3:2]}, {6'h00, swing_setting_out});
      chk("preemph", {6'h00, e[1:0]}, {6'h00, preemphasis_setting_out});
   endtask
   // reset held 17 cycles, defaults checked while held
   task automatic do_reset();
      @(posedge mclk_in);
      reset_n_in <= 1'b0;
      repeat (16) @(posedge mclk_in);
      #1 chk("rst_boost", 8'h00, {4'h0, boost_code_out});
      chk("rst_swing", 8'h02, {6'h00, swing_setting_out});
      chk("rst_preemph", 8'h01, {6'h00, preemphasis_setting_out});
      @(posedge mclk_in);
      reset_n_in <= 1'b1;
      b0 = 8'h06;
      b1 = 8'h00;
   endtask
   // ******
   // main sequence
   // ******
   initial begin
      void'($urandom(73));
      do_reset();
      rd(8'h00, 8'h06);
      rd(8'h01, 8'h00);
      wr(8'h01, 8'hFF);
      rd(8'h01, 8'h0F);
      wr(8'h02, 8'h5A);
      rd(8'h02, 8'h00);
      // random bytes and straps cover every mode and source
      for (int i = 0; i < 400; i++) begin
         b0 = 8'($urandom);
         b1 = 8'($urandom);
         wr(8'h00, b0);
         wr(8'h01, b1);
         pins(16'($urandom));
         check();
      end
      // byte 1 stands in: adaptive high, level middle, register pre-emphasis 6dB
      b0 = 8'h04;
      b1 = 8'h07;
      wr(8'h00, b0);
      wr(8'h01, b1);
      pins(16'h0000);
      check();
      // second reset in mid-run restores the byte defaults
      do_reset();
      rd(8'h00, 8'h06);
      stop_test();
   end
endmodule // rdsel_bench
